// ### verilog/tmr_pkg.sv
// package: register map, field positions and constants of the 8-bit timer core
`default_nettype none
package tmr_pkg;
   localparam logic [2:0] ADDR_CTRL_A   = 3'h0;
   localparam logic [2:0] ADDR_CTRL_B   = 3'h1;
   localparam logic [2:0] ADDR_COUNT    = 3'h2;
   localparam logic [2:0] ADDR_CMP_A    = 3'h3;
   localparam logic [2:0] ADDR_CMP_B    = 3'h4;
   localparam logic [2:0] ADDR_MASK     = 3'h5;
   localparam logic [2:0] ADDR_FLAG     = 3'h6;
   // control_reg_a fields
   localparam int         CA_WGM_LO     = 0;
   localparam int         CA_COMB_LO    = 4;
   localparam int         CA_COMA_LO    = 6;
   // control_reg_b fields
   localparam int         CB_CS_LO      = 0;
   localparam int         CB_WGM_HI     = 3;
   localparam int         CB_FOCB       = 6;
   localparam int         CB_FOCA       = 7;
   // flag and mask bit positions
   localparam int         FL_OVF        = 0;
   localparam int         FL_CMPA       = 1;
   localparam int         FL_CMPB       = 2;
   localparam logic [7:0] RESET_VAL     = 8'h00;
   localparam logic [7:0] CNT_BOTTOM    = 8'h00;
   localparam logic [7:0] CNT_MAX       = 8'hFF;
   localparam logic [7:0] CNT_ONE       = 8'h01;
   localparam logic [2:0] CS_STOP       = 3'h0;
   localparam logic [2:0] CS_DIV1       = 3'h1;
   localparam logic [2:0] CS_DIV8       = 3'h2;
   localparam logic [2:0] CS_DIV64      = 3'h3;
   localparam logic [2:0] CS_DIV256     = 3'h4;
   localparam logic [2:0] CS_DIV1024    = 3'h5;
   localparam logic [2:0] CS_EXT_FALL   = 3'h6;
   localparam logic [2:0] CS_EXT_RISE   = 3'h7;
   localparam int         PRESC_W       = 10;
   typedef enum logic [2:0] {
      TMR_NORMAL, TMR_PC_MAX, TMR_CTC, TMR_FAST_MAX,
      TMR_RSV4, TMR_PC_OCRA, TMR_RSV6, TMR_FAST_OCRA
   } tmr_mode_e;
endpackage : tmr_pkg
`default_nettype wire

// ### verilog/tmr_core.sv
// 8-bit timer/counter core with two compare units and register port
`default_nettype none
module tmr_core
   import tmr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output logic      [7:0] rdata,
   input  wire logic       ext_count_pin,
   input  wire logic [2:0] irq_ack,
   output logic      [2:0] irq_req,
   output logic            compare_out_a,
   output logic            compare_out_b
);
   logic [7:0]         count_value;
   logic [7:0]         control_reg_a;
   logic [7:0]         control_reg_b;
   logic [7:0]         compare_value_a;
   logic [7:0]         compare_value_b;
   logic [7:0]         cmp_buf_a;
   logic [7:0]         cmp_buf_b;
   logic [2:0]         timer_mask_reg;
   logic [2:0]         timer_flag_reg;
   logic [PRESC_W-1:0] presc;
   logic               ext_s1, ext_s2, ext_s3;
   logic               timer_clock;
   logic               count_down;
   logic               block_match;
   logic [1:0]         match_q;
   tmr_mode_e          mode;
   logic [2:0]         clock_select;
   logic               pwm_mode, phase_mode;
   logic [7:0]         top_val;
   logic               at_top, at_bottom;
   logic [1:0]         match_now;
   logic [7:0]         next_count;
   logic               next_down;
   logic               upd_point;
   logic               cnt_wr;
   logic [2:0]         flag_clr;

   // clear-on-write-one plus service acknowledge
   function automatic logic [2:0] flag_clear(input logic wr, input logic [7:0] d, input logic [2:0] ack);
      flag_clear = ack | ({3{wr}} & d[2:0]);
   endfunction : flag_clear

   assign mode         = tmr_mode_e'({control_reg_b[CB_WGM_HI], control_reg_a[CA_WGM_LO +: 2]});
   assign clock_select = control_reg_b[CB_CS_LO +: 3];
   assign pwm_mode     = (mode != TMR_NORMAL) && (mode != TMR_CTC);
   assign phase_mode   = (mode == TMR_PC_MAX) || (mode == TMR_PC_OCRA);
   assign top_val      = (mode == TMR_CTC || mode == TMR_PC_OCRA || mode == TMR_FAST_OCRA)
                         ? compare_value_a : CNT_MAX;
   assign at_top       = (count_value == top_val);
   assign at_bottom    = (count_value == CNT_BOTTOM);
   assign cnt_wr       = wr_stb && (addr == ADDR_COUNT);
   assign flag_clr     = flag_clear(wr_stb && addr == ADDR_FLAG, wdata, irq_ack);
   assign match_now[0] = (count_value == compare_value_a);
   assign match_now[1] = (count_value == compare_value_b);

   // free prescaler; divided ticks act as one-cycle enables
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         presc <= '0;
      end else if (clock_select == CS_STOP) begin
         presc <= '0;
      end else begin
         presc <= presc + 1'b1;
      end
   end

   // external pin passes two flops before the edge detector reads it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= ext_count_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   always_comb begin
      case (clock_select)
         CS_STOP:     timer_clock = 1'b0;
         CS_DIV1:     timer_clock = 1'b1;
         CS_DIV8:     timer_clock = (presc[2:0] == 3'h7);
         CS_DIV64:    timer_clock = (presc[5:0] == 6'h3F);
         CS_DIV256:   timer_clock = (presc[7:0] == 8'hFF);
         CS_DIV1024:  timer_clock = (presc == 10'h3FF);
         CS_EXT_FALL: timer_clock = ext_s3 && !ext_s2;
         CS_EXT_RISE: timer_clock = !ext_s3 && ext_s2;
         default:     timer_clock = 1'b0;
      endcase
   end

   // next counter value and direction for one timer clock
   always_comb begin
      next_count = count_value;
      next_down  = count_down;
      case (mode)
         TMR_NORMAL: next_count = count_value + CNT_ONE;
         TMR_CTC, TMR_FAST_MAX, TMR_FAST_OCRA: begin
            if (at_top) begin
               next_count = CNT_BOTTOM;
            end else begin
               next_count = count_value + CNT_ONE;
            end
         end
         TMR_PC_MAX, TMR_PC_OCRA: begin
            if (at_top) begin
               next_down = 1'b1;
            end else if (at_bottom) begin
               next_down = 1'b0;
            end
            next_count = next_down ? count_value - CNT_ONE : count_value + CNT_ONE;
         end
         default: next_count = count_value + CNT_ONE;
      endcase
   end

   // cpu write wins over a same-cycle count or clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count_value <= RESET_VAL;
         count_down  <= 1'b0;
      end else if (cnt_wr) begin
         count_value <= wdata;
      end else if (timer_clock) begin
         count_value <= next_count;
         count_down  <= next_down;
      end
   end

   // a counter write blocks compare matches through the next timer clock
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         block_match <= 1'b0;
      end else if (cnt_wr) begin
         block_match <= 1'b1;
      end else if (timer_clock) begin
         block_match <= 1'b0;
      end
   end

   // match latched on one timer clock, flagged on the next
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         match_q <= 2'b00;
      end else if (timer_clock) begin
         match_q <= block_match ? 2'b00 : match_now;
      end
   end

   // pwm compare values reload at top (fast) or bottom (phase)
   assign upd_point = timer_clock && (phase_mode ? at_bottom : at_top);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmp_buf_a       <= RESET_VAL;
         cmp_buf_b       <= RESET_VAL;
         compare_value_a <= RESET_VAL;
         compare_value_b <= RESET_VAL;
      end else begin
         if (wr_stb && addr == ADDR_CMP_A) begin
            cmp_buf_a <= wdata;
         end
         if (wr_stb && addr == ADDR_CMP_B) begin
            cmp_buf_b <= wdata;
         end
         // non-pwm modes write straight through, no double buffering
         if (!pwm_mode) begin
            if (wr_stb && addr == ADDR_CMP_A) begin
               compare_value_a <= wdata;
            end
            if (wr_stb && addr == ADDR_CMP_B) begin
               compare_value_b <= wdata;
            end
         end else if (upd_point) begin
            compare_value_a <= cmp_buf_a;
            compare_value_b <= cmp_buf_b;
         end
      end
   end

   // control registers; force bits are strobes and read back zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         control_reg_a  <= RESET_VAL;
         control_reg_b  <= RESET_VAL;
         timer_mask_reg <= 3'h0;
      end else begin
         control_reg_b[CB_FOCB] <= 1'b0;
         control_reg_b[CB_FOCA] <= 1'b0;
         if (wr_stb && addr == ADDR_CTRL_A) begin
            control_reg_a <= wdata;
         end
         if (wr_stb && addr == ADDR_CTRL_B) begin
            control_reg_b <= wdata;
         end
         if (wr_stb && addr == ADDR_MASK) begin
            timer_mask_reg <= wdata[2:0];
         end
      end
   end

   // flags: hardware set beats any same-cycle clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timer_flag_reg <= 3'h0;
      end else begin
         timer_flag_reg[FL_OVF]  <= (timer_clock && (pwm_mode ? (phase_mode ? at_bottom : at_top)
                                                   : (mode == TMR_NORMAL && count_value == CNT_MAX)))
                                  || (timer_flag_reg[FL_OVF] && !flag_clr[FL_OVF]);
         timer_flag_reg[FL_CMPA] <= (timer_clock && match_q[0])
                                  || (timer_flag_reg[FL_CMPA] && !flag_clr[FL_CMPA]);
         timer_flag_reg[FL_CMPB] <= (timer_clock && match_q[1])
                                  || (timer_flag_reg[FL_CMPB] && !flag_clr[FL_CMPB]);
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_req <= 3'h0;
      end else begin
         irq_req <= timer_flag_reg & timer_mask_reg;
      end
   end

   // waveform outputs: com 01 toggle, 10 clear, 11 set on match (non-pwm);
   // pwm modes: non-inverted clears on match; only fast pwm also sets at bottom
   generate
      for (genvar u = 0; u < 2; u++) begin : g_wave
         logic [1:0] com;
         logic       force_s;
         logic       wave;
         assign com     = (u == 0) ? control_reg_a[CA_COMA_LO +: 2] : control_reg_a[CA_COMB_LO +: 2];
         assign force_s = (u == 0) ? control_reg_b[CB_FOCA] : control_reg_b[CB_FOCB];
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               wave <= 1'b0;
            end else if (!pwm_mode) begin
               if ((timer_clock && match_q[u]) || force_s) begin
                  case (com)
                     2'h1:    wave <= !wave;
                     2'h2:    wave <= 1'b0;
                     2'h3:    wave <= 1'b1;
                     default: wave <= wave;
                  endcase
               end
            end else if (com[1] && timer_clock) begin
               if (match_q[u]) begin
                  wave <= com[0];
               end else if (!phase_mode && at_bottom) begin
                  wave <= !com[0];
               end
            end
         end
         if (u == 0) begin : g_a
            assign compare_out_a = wave;
         end else begin : g_b
            assign compare_out_b = wave;
         end
      end
   endgenerate

   // read data valid the cycle after the read strobe only
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         case (addr)
            ADDR_CTRL_A: rdata <= control_reg_a;
            ADDR_CTRL_B: rdata <= {2'b00, control_reg_b[5:0]};
            ADDR_COUNT:  rdata <= count_value;
            ADDR_CMP_A:  rdata <= cmp_buf_a;
            ADDR_CMP_B:  rdata <= cmp_buf_b;
            ADDR_MASK:   rdata <= {5'h00, timer_mask_reg};
            ADDR_FLAG:   rdata <= {5'h00, timer_flag_reg};
            default:     rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule : tmr_core
`default_nettype wire

// ### verification/tmr_core_properties.sv
// checker: register port and request relations of the timer core
`default_nettype none
module tmr_core_chk
   import tmr_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rdata,
   input wire logic [2:0] irq_req
);
   logic [7:0] cmp_a, cmp_b, cnt_w;
   logic [3:0] cb;
   logic [2:0] msk;
   logic       held;

   // shadow of software writes; held means the counter cannot have moved since the last count write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmp_a <= 8'h00;
         cmp_b <= 8'h00;
         cnt_w <= 8'h00;
         cb    <= 4'h0;
         msk   <= 3'h0;
         held  <= 1'b1;
      end else if (wr_stb) begin
         case (addr)
            ADDR_CTRL_B: begin
               cb   <= wdata[3:0];
               held <= held && (wdata[2:0] == CS_STOP);
            end
            ADDR_COUNT: begin
               cnt_w <= wdata;
               held  <= (cb[2:0] == CS_STOP);
            end
            ADDR_CMP_A: cmp_a <= wdata;
            ADDR_CMP_B: cmp_b <= wdata;
            ADDR_MASK:  msk <= wdata[2:0];
            default: ;
         endcase
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_rd(logic [2:0] a);
      rd_stb && addr == a;
   endsequence
   property p_back(logic [2:0] a, logic [7:0] v);
      s_rd(a) |=> rdata == $past(v);
   endproperty

   a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00) else $error("read data outside read slot");
   a_unmapped_zero: assert property (s_rd(3'h7) |=> rdata == 8'h00) else $error("unmapped read not zero");
   a_cmp_a_back: assert property (p_back(ADDR_CMP_A, cmp_a)) else $error("compare a readback");
   a_cmp_b_back: assert property (p_back(ADDR_CMP_B, cmp_b)) else $error("compare b readback");
   a_count_held: assert property (s_rd(ADDR_COUNT) ##0 held |=> rdata == $past(cnt_w))
      else $error("stopped counter moved");
   a_ctrl_b_back: assert property (s_rd(ADDR_CTRL_B) |=> rdata[7:6] == 2'b00 && rdata[3:0] == $past(cb))
      else $error("control b readback");
   a_mask_back: assert property (s_rd(ADDR_MASK) |=> rdata[2:0] == $past(msk)) else $error("mask readback");
   a_irq_masked: assert property ((irq_req & ~$past(msk)) == 3'h0) else $error("masked request seen");
   a_mask_off_quiet: assert property (wr_stb && addr == ADDR_MASK && wdata[2:0] == 3'h0 |-> ##2 irq_req == 3'h0)
      else $error("request after masking");
endmodule : tmr_core_chk

bind tmr_core tmr_core_chk chk_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
   .rd_stb(rd_stb), .rdata(rdata), .irq_req(irq_req));
`default_nettype wire

// ### verification/tmr_pin_drv.sv
// partner: event source on the external count pin
`default_nettype none
module tmr_pin_drv (
   input  wire logic mclk,
   output logic      pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pin = 1'b0;

   // slow pulses, well above the pin synchroniser latency
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge mclk);
         pin <= 1'b1;
         repeat (4) @(posedge mclk);
         pin <= 1'b0;
      end
   endtask : pulses
endmodule : tmr_pin_drv
`default_nettype wire

// ### verification/test_timer8_counter_core.sv
// testbench: register-level checks of the timer core
`default_nettype none
module test_timer8_counter_core
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       mclk, rstn, wr_stb, rd_stb, pin, cmp_out_a, cmp_out_b;
   logic [2:0] addr, irq_ack, irq_req;
   logic [7:0] wdata, rdata, v, w;
   int         failures, checked;

   tmr_core dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .ext_count_pin(pin), .irq_ack(irq_ack), .irq_req(irq_req), .compare_out_a(cmp_out_a),
      .compare_out_b(cmp_out_b));
   tmr_pin_drv pin_u (.mclk(mclk), .pin(pin));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic rc(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk8(d, exp);
   endtask : rc

   initial begin
      #20us;
      failures++;
      $display("Error at %0t: watchdog expired", $time);
      close_out();
   end

   initial begin
      rstn = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      irq_ack = 3'h0;
      failures = 0;
      checked = 0;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rc(i[2:0], 8'h00);
      end
      $display("reset values done");
      wr(ADDR_CMP_A, 8'hA5);
      wr(ADDR_CMP_B, 8'h5A);
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_COUNT, 8'hC3);
      wr(3'h7, 8'hFF);
      rc(ADDR_CMP_A, 8'hA5);
      rc(ADDR_CMP_B, 8'h5A);
      rc(3'h7, 8'h00);
      repeat (20) @(posedge mclk);
      rc(ADDR_COUNT, 8'hC3);
      $display("register access done");
      // mode zero from FE: wraps within the wait, so the overflow flag must be up
      wr(ADDR_COUNT, 8'hFE);
      wr(ADDR_CTRL_B, {5'h0, CS_DIV1});
      repeat (6) @(posedge mclk);
      rd(ADDR_COUNT, v);
      rd(ADDR_COUNT, w);
      chk8(w, v + 8'h02);
      wr(ADDR_COUNT, 8'h40);
      rc(ADDR_COUNT, 8'h41);
      wr(ADDR_CTRL_B, 8'h00);
      rc(ADDR_FLAG, 8'h01);
      chk8({5'h0, irq_req}, 8'h01);
      wr(ADDR_FLAG, 8'h01);
      rc(ADDR_FLAG, 8'h00);
      chk8({5'h0, irq_req}, 8'h00);
      $display("overflow done");
      // force strobes in normal mode drive both outputs with the set action
      wr(ADDR_CTRL_A, 8'hF0);
      wr(ADDR_CTRL_B, 8'hC0);
      repeat (2) @(posedge mclk);
      chk8({7'h0, cmp_out_a}, 8'h01);
      chk8({7'h0, cmp_out_b}, 8'h01);
      $display("force compare done");
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CMP_A, 8'h05);
      wr(ADDR_CMP_B, 8'h03);
      wr(ADDR_CTRL_A, 8'h02);
      wr(ADDR_CTRL_B, {5'h0, CS_DIV1});
      for (int i = 0; i < 8; i++) begin
         rd(ADDR_COUNT, v);
         chk8({7'h0, v <= 8'h05}, 8'h01);
      end
      wr(ADDR_CTRL_B, 8'h00);
      rc(ADDR_FLAG, 8'h06);
      chk8({5'h0, irq_req}, 8'h00);
      @(posedge mclk);
      irq_ack <= 3'h2;
      @(posedge mclk);
      irq_ack <= 3'h0;
      rc(ADDR_FLAG, 8'h04);
      wr(ADDR_FLAG, 8'h04);
      rc(ADDR_FLAG, 8'h00);
      $display("clear on match done");
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL_B, {5'h0, CS_EXT_RISE});
      pin_u.pulses(5);
      repeat (8) @(posedge mclk);
      rc(ADDR_COUNT, 8'h05);
      wr(ADDR_CTRL_B, {5'h0, CS_EXT_FALL});
      pin_u.pulses(3);
      repeat (8) @(posedge mclk);
      wr(ADDR_CTRL_B, 8'h00);
      rc(ADDR_COUNT, 8'h08);
      wr(ADDR_MASK, 8'h00);
      $display("external count done");
      close_out();
   end
endmodule : test_timer8_counter_core
`default_nettype wire
